// ===== ffpg_pkg.sv
// Constants, field layout and carrier types of the charger flag and power-good block.
// Assumes a 10 MHz system clock and word-aligned 32-bit Avalon-MM register access.
package ffpg_pkg;

  // Clock and timing
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned TICK_TIME_US  = 1000;
  localparam int unsigned TICK_CYCLES   = (TICK_TIME_US * 1000) / CLK_PERIOD_NS;

  // Register byte offsets
  localparam logic [4:0] OFS_FLAG_STATUS  = 5'h00;
  localparam logic [4:0] OFS_FLAG_MASK    = 5'h04;
  localparam logic [4:0] OFS_LIVE_STATUS  = 5'h08;
  localparam logic [4:0] OFS_PIN_CONTROL  = 5'h0c;
  localparam logic [4:0] OFS_WAKE1_TIME   = 5'h10;
  localparam logic [4:0] OFS_WAKE2_TIME   = 5'h14;
  localparam logic [4:0] OFS_WARN_TIME    = 5'h18;
  localparam logic [4:0] OFS_SAFETY_LIMIT = 5'h1c;

  // Flag bit positions in status, mask and live registers
  localparam int unsigned FLAG_WIDTH      = 13;
  localparam int unsigned FLAG_TS_WARM    = 0;
  localparam int unsigned FLAG_TS_HOT     = 1;
  localparam int unsigned FLAG_CONV_DONE  = 2;
  localparam int unsigned FLAG_CMP1       = 3;
  localparam int unsigned FLAG_CMP2       = 4;
  localparam int unsigned FLAG_CMP3       = 5;
  localparam int unsigned FLAG_TS_OPEN    = 6;
  localparam int unsigned FLAG_WATCHDOG   = 7;
  localparam int unsigned FLAG_TIMER_EXP  = 8;
  localparam int unsigned FLAG_LDO_OCP    = 9;
  localparam int unsigned FLAG_WAKE1      = 10;
  localparam int unsigned FLAG_WAKE2      = 11;
  localparam int unsigned FLAG_RESET_WARN = 12;

  // Pin control field positions
  localparam int unsigned PIN_SEL_LSB   = 0;
  localparam int unsigned PIN_LEVEL_BIT = 2;

  // Reset values
  localparam logic [FLAG_WIDTH-1:0] RST_FLAG_MASK    = 13'h0000;
  localparam logic [1:0]            RST_OUTPUT_SEL   = 2'h0;
  localparam logic                  RST_GPO_LEVEL    = 1'b1;
  localparam logic [15:0]           RST_WAKE1_TIME   = 16'h0064;
  localparam logic [15:0]           RST_WAKE2_TIME   = 16'h03e8;
  localparam logic [15:0]           RST_WARN_TIME    = 16'h2710;
  localparam logic [23:0]           RST_SAFETY_LIMIT = 24'h36ee80;

  typedef enum logic [1:0] {
    SEL_SUPPLY  = 2'b00,
    SEL_MIRROR  = 2'b01,
    SEL_GPO     = 2'b10,
    SEL_GPO_ALT = 2'b11
  } ffpg_sel_type;

  // Analog comparator results, all levels
  typedef struct packed {
    logic ts_warm;
    logic ts_hot;
    logic ts_open;
    logic cmp1;
    logic cmp2;
    logic cmp3;
    logic wd_fault;
    logic ldo_ocp;
  } ffpg_cond_type;

endpackage : ffpg_pkg

// ===== ffpg_top.sv
// Flag/interrupt logic and power-good open-drain pin of a charge manager.
// Assumes synchronous inputs on sys_clk and an Avalon-MM master with waitrequest.
// What this block does
// - Each flag's status rising edge sets a sticky bit and may raise interrupt.
// - Conversion finish sets its flag; charger and timer ignore it.
// - Default mode drives power-good pin low while supply valid, else released.
// - Select 01 makes the pin mirror the push-button input.
// - Select 1x makes the pin a host-controlled general-purpose open-drain output.
// - In that mode level bit 0 pulls low, 1 releases; host writes it.
module ffpg_top
  import ffpg_pkg::*;
#(
  parameter int unsigned TICK_COUNT = TICK_CYCLES
)
(
  input  wire logic                  sys_clk,
  input  wire logic                  reset,
  input  wire logic                  clk_en,
  input  wire logic [4:0]            avs_address,
  input  wire logic                  avs_read,
  input  wire logic                  avs_write,
  input  wire logic [31:0]           avs_writedata,
  input  wire logic [3:0]            avs_byteenable,
  output logic      [31:0]           avs_readdata,
  output logic                       avs_waitrequest,
  input  wire ffpg_cond_type         cond,
  input  wire logic                  conv_done,
  input  wire logic                  input_supply,
  input  wire logic                  charge_enable,
  input  wire logic                  charge_active,
  input  wire logic                  push_button_input,
  output logic                       charge_allowed,
  output logic                       supply_valid_pin_out,
  output logic                       supply_valid_pin_oe_n,
  output logic                       irq
);

  logic                  ack;
  logic [FLAG_WIDTH-1:0] flag_status;
  logic [FLAG_WIDTH-1:0] flag_mask;
  logic [FLAG_WIDTH-1:0] live;
  logic [FLAG_WIDTH-1:0] live_prev;
  logic [FLAG_WIDTH-1:0] events;
  logic [FLAG_WIDTH-1:0] clear_bits;
  ffpg_sel_type          output_select_field;
  logic                  gpo_level_bit;
  logic [15:0]           wake1_time;
  logic [15:0]           wake2_time;
  logic [15:0]           warn_time;
  logic [23:0]           safety_limit;
  logic [13:0]           tick_cnt;
  logic                  tick;
  logic [15:0]           low_ms;
  logic [23:0]           safety_cnt;
  logic                  charge_timer_expired_flag;
  logic                  supply_prev;
  logic                  enable_prev;
  logic                  toggle_seen;
  logic                  wr_now;
  logic                  next_pin_oe_n;

  // Bus: one wait cycle, then the request completes
  assign avs_waitrequest = (avs_read | avs_write) & ~ack;
  assign wr_now          = clk_en & avs_write & ack;

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      ack <= 1'b0;
    else if (clk_en)
      ack <= (avs_read | avs_write) & ~ack;
  end

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      avs_readdata <= 32'h0000_0000;
    else if (clk_en && avs_read && !ack)
    begin
      case (avs_address)
        OFS_FLAG_STATUS:  avs_readdata <= {19'h0, flag_status};
        OFS_FLAG_MASK:    avs_readdata <= {19'h0, flag_mask};
        OFS_LIVE_STATUS:  avs_readdata <= {19'h0, live};
        OFS_PIN_CONTROL:  avs_readdata <= {29'h0, gpo_level_bit, output_select_field};
        OFS_WAKE1_TIME:   avs_readdata <= {16'h0, wake1_time};
        OFS_WAKE2_TIME:   avs_readdata <= {16'h0, wake2_time};
        OFS_WARN_TIME:    avs_readdata <= {16'h0, warn_time};
        OFS_SAFETY_LIMIT: avs_readdata <= {8'h0, safety_limit};
        default:          avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

  // Configuration registers
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      flag_mask           <= RST_FLAG_MASK;
      output_select_field <= ffpg_sel_type'(RST_OUTPUT_SEL);
      gpo_level_bit       <= RST_GPO_LEVEL;
      wake1_time          <= RST_WAKE1_TIME;
      wake2_time          <= RST_WAKE2_TIME;
      warn_time           <= RST_WARN_TIME;
      safety_limit        <= RST_SAFETY_LIMIT;
    end
    else if (wr_now)
    begin
      case (avs_address)
        OFS_FLAG_MASK:
        begin
          if (avs_byteenable[0]) flag_mask[7:0] <= avs_writedata[7:0];
          if (avs_byteenable[1]) flag_mask[12:8] <= avs_writedata[12:8];
        end
        OFS_PIN_CONTROL:
        begin
          if (avs_byteenable[0])
          begin
            output_select_field <= ffpg_sel_type'(avs_writedata[PIN_SEL_LSB +: 2]);
            gpo_level_bit       <= avs_writedata[PIN_LEVEL_BIT];
          end
        end
        OFS_WAKE1_TIME:
        begin
          if (avs_byteenable[0]) wake1_time[7:0] <= avs_writedata[7:0];
          if (avs_byteenable[1]) wake1_time[15:8] <= avs_writedata[15:8];
        end
        OFS_WAKE2_TIME:
        begin
          if (avs_byteenable[0]) wake2_time[7:0] <= avs_writedata[7:0];
          if (avs_byteenable[1]) wake2_time[15:8] <= avs_writedata[15:8];
        end
        OFS_WARN_TIME:
        begin
          if (avs_byteenable[0]) warn_time[7:0] <= avs_writedata[7:0];
          if (avs_byteenable[1]) warn_time[15:8] <= avs_writedata[15:8];
        end
        OFS_SAFETY_LIMIT:
        begin
          if (avs_byteenable[0]) safety_limit[7:0] <= avs_writedata[7:0];
          if (avs_byteenable[1]) safety_limit[15:8] <= avs_writedata[15:8];
          if (avs_byteenable[2]) safety_limit[23:16] <= avs_writedata[23:16];
        end
        default: ;
      endcase
    end
  end

  // Millisecond tick
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      tick_cnt <= 14'h0000;
    else if (clk_en)
      tick_cnt <= tick ? 14'h0000 : tick_cnt + 14'h0001;
  end
  assign tick = (tick_cnt == 14'(TICK_COUNT - 1));

  // Button held-low time in milliseconds, saturating
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      low_ms <= 16'h0000;
    else if (clk_en)
    begin
      if (push_button_input)
        low_ms <= 16'h0000;
      else if (tick && low_ms != 16'hffff)
        low_ms <= low_ms + 16'h0001;
    end
  end

  // Safety timer and toggle release
  assign toggle_seen = (input_supply != supply_prev) | (charge_enable != enable_prev);

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      supply_prev               <= 1'b0;
      enable_prev               <= 1'b0;
      safety_cnt                <= 24'h000000;
      charge_timer_expired_flag <= 1'b0;
    end
    else if (clk_en)
    begin
      supply_prev <= input_supply;
      enable_prev <= charge_enable;
      if (charge_timer_expired_flag)
      begin
        safety_cnt <= 24'h000000;
        if (toggle_seen)
          charge_timer_expired_flag <= 1'b0;
      end
      else if (safety_limit != 24'h000000 && safety_cnt >= safety_limit)
        charge_timer_expired_flag <= 1'b1;
      else if (charge_active && tick)
        safety_cnt <= safety_cnt + 24'h000001;
    end
  end

  // Conversion-complete has no term here
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      charge_allowed <= 1'b0;
    else if (clk_en)
      charge_allowed <= charge_enable & input_supply & ~charge_timer_expired_flag;
  end

  // Live flag levels
  always_comb
  begin
    live                  = '0;
    live[FLAG_TS_WARM]    = cond.ts_warm;
    live[FLAG_TS_HOT]     = cond.ts_hot;
    live[FLAG_CONV_DONE]  = conv_done;
    live[FLAG_CMP1]       = cond.cmp1;
    live[FLAG_CMP2]       = cond.cmp2;
    live[FLAG_CMP3]       = cond.cmp3;
    live[FLAG_TS_OPEN]    = cond.ts_open;
    live[FLAG_WATCHDOG]   = cond.wd_fault;
    live[FLAG_TIMER_EXP]  = charge_timer_expired_flag;
    live[FLAG_LDO_OCP]    = cond.ldo_ocp;
    live[FLAG_WAKE1]      = (low_ms >= wake1_time);
    live[FLAG_WAKE2]      = (low_ms >= wake2_time);
    live[FLAG_RESET_WARN] = (low_ms >= warn_time);
  end

  assign events     = live & ~live_prev;
  assign clear_bits = (wr_now && avs_address == OFS_FLAG_STATUS) ?
                      (avs_writedata[FLAG_WIDTH-1:0] & {{5{avs_byteenable[1]}},
                      {8{avs_byteenable[0]}}}) : '0;

  // Sticky flags: a new event wins over a write-one clear
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      live_prev   <= '0;
      flag_status <= '0;
    end
    else if (clk_en)
    begin
      live_prev   <= live;
      flag_status <= (flag_status & ~clear_bits) | events;
    end
  end

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      irq <= 1'b0;
    else if (clk_en)
      irq <= |(flag_status & flag_mask);
  end

  // Power-good open-drain pin; low enable means driving low
  always_comb
  begin
    case (output_select_field)
      SEL_SUPPLY:  next_pin_oe_n = ~input_supply;
      SEL_MIRROR:  next_pin_oe_n = push_button_input;
      SEL_GPO:     next_pin_oe_n = gpo_level_bit;
      SEL_GPO_ALT: next_pin_oe_n = gpo_level_bit;
      default:     next_pin_oe_n = 1'b1;
    endcase
  end

  assign supply_valid_pin_out = 1'b0;

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      supply_valid_pin_oe_n <= 1'b1;
    else if (clk_en)
      supply_valid_pin_oe_n <= next_pin_oe_n;
  end

  // Checks
  a_flag_on_rise: assert property (@(posedge sys_clk) disable iff (reset)
    clk_en && (|events) |=> ((flag_status & $past(events)) == $past(events)))
    else $error("rising flag not latched");

  a_irq_from_mask: assert property (@(posedge sys_clk) disable iff (reset)
    clk_en && (|(flag_status & flag_mask)) |=> irq)
    else $error("unmasked flag without interrupt");

  a_conv_done_flag: assert property (@(posedge sys_clk) disable iff (reset)
    clk_en && conv_done && !live_prev[FLAG_CONV_DONE] |=> flag_status[FLAG_CONV_DONE])
    else $error("conversion flag missing");

  a_conv_no_charge: assert property (@(posedge sys_clk) disable iff (reset)
    clk_en && conv_done && charge_enable && input_supply && !charge_timer_expired_flag
    |=> charge_allowed)
    else $error("conversion affected charging");

  a_expired_blocks: assert property (@(posedge sys_clk) disable iff (reset)
    clk_en && charge_timer_expired_flag && !toggle_seen |=> charge_timer_expired_flag
    ##0 !charge_allowed && safety_cnt == 24'h000000)
    else $error("expired timer let charge run");

  a_toggle_clears: assert property (@(posedge sys_clk) disable iff (reset)
    clk_en && charge_timer_expired_flag && toggle_seen |=> !charge_timer_expired_flag)
    else $error("toggle did not clear timer flag");

  a_pin_supply: assert property (@(posedge sys_clk) disable iff (reset)
    clk_en && output_select_field == SEL_SUPPLY |=> supply_valid_pin_oe_n == !$past(input_supply))
    else $error("pin not tracking supply");

  a_pin_mirror: assert property (@(posedge sys_clk) disable iff (reset)
    clk_en && output_select_field == SEL_MIRROR |=>
    supply_valid_pin_oe_n == $past(push_button_input))
    else $error("pin not mirroring button");

  a_pin_gpo: assert property (@(posedge sys_clk) disable iff (reset)
    clk_en && output_select_field[1] |=> supply_valid_pin_oe_n == $past(gpo_level_bit))
    else $error("pin not following level bit");

  a_gpo_write: assert property (@(posedge sys_clk) disable iff (reset)
    wr_now && avs_address == OFS_PIN_CONTROL && avs_byteenable[0] && avs_writedata[1]
    ##1 clk_en |=> supply_valid_pin_oe_n == $past(avs_writedata[PIN_LEVEL_BIT], 2))
    else $error("written level not on pin");

  a_wake_flag: assert property (@(posedge sys_clk) disable iff (reset)
    clk_en && low_ms >= wake1_time && !live_prev[FLAG_WAKE1] |=> flag_status[FLAG_WAKE1])
    else $error("wake flag not set");

  c_timer_expire: cover property (@(posedge sys_clk) disable iff (reset)
    $rose(charge_timer_expired_flag));
  c_reset_warn: cover property (@(posedge sys_clk) disable iff (reset)
    $rose(flag_status[FLAG_RESET_WARN]));
  c_irq_raise: cover property (@(posedge sys_clk) disable iff (reset) $rose(irq));
  c_gpo_low: cover property (@(posedge sys_clk) disable iff (reset)
    output_select_field[1] && !supply_valid_pin_oe_n);

endmodule // ffpg_top

// ===== ffpg_host_model.sv
// Host-side model: pull-up on the power-good pin and an interrupt edge counter.
// Assumes the pin is open drain with an external pull-up to the logic rail.
module ffpg_host_model
  import ffpg_pkg::*;
(
  input  wire logic sys_clk,
  input  wire logic reset,
  input  wire logic pin_out,
  input  wire logic pin_oe_n,
  input  wire logic irq,
  output logic      pin_level,
  output int        irq_edges
);
  timeunit 1ns;
  timeprecision 1ns;
  logic irq_prev;
  // Released pin reads high through the pull-up
  assign pin_level = pin_oe_n ? 1'b1 : pin_out;
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      irq_prev  <= 1'b0;
      irq_edges <= 0;
    end
    else
    begin
      irq_prev <= irq;
      if (irq && !irq_prev)
        irq_edges <= irq_edges + 1;
    end
  end
endmodule // ffpg_host_model

// ===== ffpg_top_test.sv
// Self-checking bench of the flag, interrupt and power-good pin block.
// Assumes a 4-cycle ms tick and an Avalon-MM master driven from this bench.
module ffpg_top_test;
  import ffpg_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic          sys_clk = 1'b0;
  logic          reset = 1'b1;
  logic          clk_en = 1'b1;
  logic [4:0]    avs_address = '0;
  logic          avs_read = 1'b0;
  logic          avs_write = 1'b0;
  logic [31:0]   avs_writedata = '0;
  logic [31:0]   avs_readdata;
  logic          avs_waitrequest;
  ffpg_cond_type cond = '0;
  logic          conv_done = 1'b0;
  logic          input_supply = 1'b0;
  logic          charge_enable = 1'b0;
  logic          charge_active = 1'b0;
  logic          push_button_input = 1'b1;
  logic          charge_allowed;
  logic          pin_out;
  logic          pin_oe_n;
  logic          irq;
  logic          pin_level;
  int            irq_edges;
  int            bad_count = 0;
  int            comparisons = 0;
  always #50 sys_clk = ~sys_clk;
  ffpg_top #(.TICK_COUNT(4)) DUT (.sys_clk(sys_clk), .reset(reset), .clk_en(clk_en),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .cond(cond), .conv_done(conv_done),
    .input_supply(input_supply), .charge_enable(charge_enable),
    .charge_active(charge_active), .push_button_input(push_button_input),
    .charge_allowed(charge_allowed), .supply_valid_pin_out(pin_out),
    .supply_valid_pin_oe_n(pin_oe_n), .irq(irq));
  ffpg_host_model host (.sys_clk(sys_clk), .reset(reset), .pin_out(pin_out),
    .pin_oe_n(pin_oe_n), .irq(irq), .pin_level(pin_level), .irq_edges(irq_edges));
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  // Request held until an edge with waitrequest low; data taken at that edge
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    @(posedge sys_clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= !wr;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (avs_waitrequest !== 1'b0 && n < 50);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    check(32'(n < 50), 32'h1, "bus answer");
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [4:0] a, input logic [31:0] exp, input string what);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    check(q, exp, what);
  endtask
  task automatic t_reset;
    check(32'({irq, pin_oe_n, charge_allowed}), 32'h2, "reset outputs");
    rd(OFS_FLAG_MASK, 32'(RST_FLAG_MASK), "mask");
    rd(OFS_PIN_CONTROL, 32'({RST_GPO_LEVEL, RST_OUTPUT_SEL}), "pin control");
    rd(OFS_WAKE1_TIME, 32'(RST_WAKE1_TIME), "wake1 time");
    rd(OFS_WAKE2_TIME, 32'(RST_WAKE2_TIME), "wake2 time");
    rd(OFS_WARN_TIME, 32'(RST_WARN_TIME), "warn time");
    rd(OFS_SAFETY_LIMIT, 32'(RST_SAFETY_LIMIT), "safety limit");
    rd(OFS_FLAG_STATUS, 32'h0, "status");
    wr(OFS_LIVE_STATUS, 32'h1fff);
    wr(5'h12, 32'hffff_ffff);
    rd(OFS_LIVE_STATUS, 32'h0, "live read only");
    rd(5'h12, 32'h0, "unmapped");
    $display("test reset values done");
  endtask
  task automatic t_flags;
    int pos [8] = '{0, 1, 6, 3, 4, 5, 7, 9};
    int e;
    wr(OFS_FLAG_MASK, 32'h1fff);
    for (int i = 0; i < 8; i++)
    begin
      e = irq_edges;
      cond <= ffpg_cond_type'(8'h80 >> i);
      cyc(4);
      check(32'(irq), 32'h1, "irq raised");
      check(32'(irq_edges), 32'(e + 1), "irq edge count");
      rd(OFS_FLAG_STATUS, 32'h1 << pos[i], "flag set");
      wr(OFS_FLAG_STATUS, 32'h1 << pos[i]);
      cond <= '0;
      cyc(2);
      rd(OFS_FLAG_STATUS, 32'h0, "no level or fall event");
      check(32'(irq), 32'h0, "irq cleared");
    end
    input_supply  <= 1'b1;
    charge_enable <= 1'b1;
    wr(OFS_FLAG_MASK, 32'h0);
    cyc(3);
    conv_done <= 1'b1;
    cyc(1);
    conv_done <= 1'b0;
    cyc(3);
    check(32'(irq), 32'h0, "masked irq");
    rd(OFS_FLAG_STATUS, 32'h4, "conversion flag");
    check(32'(charge_allowed), 32'h1, "charge unaffected");
    wr(OFS_FLAG_MASK, 32'h4);
    cyc(3);
    check(32'(irq), 32'h1, "unmasked irq");
    wr(OFS_FLAG_STATUS, 32'h4);
    cyc(3);
    check(32'(irq), 32'h0, "irq after clear");
    wr(OFS_FLAG_MASK, 32'h0);
    $display("test flag events done");
  endtask
  task automatic t_timer;
    wr(OFS_SAFETY_LIMIT, 32'h3);
    charge_active <= 1'b1;
    cyc(4);
    check(32'(charge_allowed), 32'h1, "charging before expiry");
    cyc(20);
    check(32'(charge_allowed), 32'h0, "charging blocked");
    rd(OFS_LIVE_STATUS, 32'h100, "expired live");
    rd(OFS_FLAG_STATUS, 32'h100, "expired status");
    charge_enable <= 1'b0;
    cyc(2);
    charge_enable <= 1'b1;
    cyc(3);
    check(32'(charge_allowed), 32'h1, "enable toggle frees");
    rd(OFS_LIVE_STATUS, 32'h0, "expiry cleared");
    wr(OFS_FLAG_STATUS, 32'h100);
    cyc(24);
    check(32'(charge_allowed), 32'h0, "timer restarted");
    rd(OFS_FLAG_STATUS, 32'h100, "second expiry");
    input_supply <= 1'b0;
    cyc(2);
    input_supply <= 1'b1;
    cyc(3);
    check(32'(charge_allowed), 32'h1, "supply toggle frees");
    charge_active <= 1'b0;
    wr(OFS_FLAG_STATUS, 32'h100);
    wr(OFS_SAFETY_LIMIT, 32'h0);
    $display("test safety timer done");
  endtask
  task automatic t_button;
    wr(OFS_WAKE1_TIME, 32'h2);
    wr(OFS_WAKE2_TIME, 32'h6);
    wr(OFS_WARN_TIME, 32'ha);
    push_button_input <= 1'b0;
    cyc(14);
    rd(OFS_FLAG_STATUS, 32'h400, "first wake only");
    cyc(14);
    rd(OFS_FLAG_STATUS, 32'hc00, "both wakes");
    cyc(18);
    rd(OFS_FLAG_STATUS, 32'h1c00, "reset warning");
    push_button_input <= 1'b1;
    cyc(3);
    rd(OFS_LIVE_STATUS, 32'h0, "live after release");
    wr(OFS_FLAG_STATUS, 32'h1c00);
    rd(OFS_FLAG_STATUS, 32'h0, "button flags cleared");
    $display("test push button done");
  endtask
  task automatic pin_is(input logic lvl, input string what);
    cyc(3);
    check(32'({pin_level, pin_oe_n}), 32'({lvl, lvl}), what);
    check(32'(pin_out & !pin_oe_n), 32'h0, "drive only low");
  endtask
  task automatic t_pin;
    pin_is(1'b0, "supply valid");
    input_supply <= 1'b0;
    pin_is(1'b1, "supply invalid");
    input_supply <= 1'b1;
    wr(OFS_PIN_CONTROL, 32'h5);
    push_button_input <= 1'b0;
    pin_is(1'b0, "mirror pressed");
    push_button_input <= 1'b1;
    pin_is(1'b1, "mirror released");
    for (int s = 2; s < 4; s++)
      for (int lv = 0; lv < 2; lv++)
      begin
        wr(OFS_PIN_CONTROL, 32'((lv << 2) | s));
        pin_is(lv[0], "general purpose level");
      end
    wr(OFS_PIN_CONTROL, 32'h4);
    pin_is(1'b0, "supply mode again");
    clk_en       <= 1'b0;
    input_supply <= 1'b0;
    cyc(3);
    check(32'(pin_oe_n), 32'h0, "frozen by clock enable");
    clk_en <= 1'b1;
    pin_is(1'b1, "supply invalid after freeze");
    $display("test pin modes done");
  endtask
  task automatic close_out;
    $display("comparisons %0d, mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    #2000000;
    bad_count++;
    $display("wrong value at %0t: watchdog expired", $time);
    close_out();
  end
  initial
  begin
    cyc(4);
    reset <= 1'b0;
    t_reset();
    t_flags();
    t_timer();
    t_button();
    t_pin();
    close_out();
  end
endmodule // ffpg_top_test
